// file: rtl/pm_cfg.svh
`ifndef PM_CFG_SVH
`define PM_CFG_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define PM_CLK_PERIOD_NS 100
`define PM_SEC_NS 1000000000
`define PM_SEC_CYCLES (`PM_SEC_NS / `PM_CLK_PERIOD_NS)
`define PM_TMO_8S 10'h008
`define PM_TMO_32S 10'h020
`define PM_TMO_2M 10'h078
`define PM_TMO_8M 10'h1e0
`define PM_TMO_16M 10'h3c0

// ----------------------------------------
// timeout selection codes
// ----------------------------------------
`define PM_SEL_DIS 3'h0
`define PM_SEL_8S 3'h1
`define PM_SEL_32S 3'h2
`define PM_SEL_2M 3'h3
`define PM_SEL_8M 3'h4
`define PM_SEL_16M 3'h5

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PM_CTRL_OFS 8'h00
`define PM_TMO_OFS 8'h04
`define PM_ACTEN_OFS 8'h08
`define PM_STAT_OFS 8'h0c
`define PM_INTSTAT_OFS 8'h10
`define PM_INTCLR_OFS 8'h14
`define PM_INTEN_OFS 8'h18

// ----------------------------------------
// field positions and widths
// ----------------------------------------
`define PM_CTRL_GMODE_LSB 0
`define PM_CTRL_DSUSP_BIT 2
`define PM_TMO_DOZE_LSB 0
`define PM_TMO_STBY_LSB 4
`define PM_TMO_SUSP_LSB 8
`define PM_TMO_DISK_LSB 12
`define PM_STAT_STATE_LSB 0
`define PM_STAT_SLOW_BIT 2
`define PM_STAT_DISK_BIT 3
`define PM_STAT_ACT_LSB 4
`define PM_SRC_W 6
`define PM_IRQ_W 13
`define PM_ACT_W 19
`define PM_ACT_DISK_BIT 3
`define PM_EVT_W 5
`define PM_EVT_DOZE 0
`define PM_EVT_STBY 1
`define PM_EVT_SUSP 2
`define PM_EVT_WAKE 3
`define PM_EVT_DISKOFF 4

`endif

// file: rtl/pm_pkg.sv
`include "pm_cfg.svh"
`default_nettype none
package pm_pkg;
   typedef enum logic [1:0] {PM_FULL, PM_DOZE, PM_STANDBY, PM_SUSPEND} pm_state_e;
   typedef enum logic [1:0] {GM_OFF, GM_USER, GM_MIN, GM_MAX} gmode_e;

   function automatic logic [9:0] sel_to_secs(input logic [2:0] sel);
      case (sel)
         `PM_SEL_8S: sel_to_secs = `PM_TMO_8S;
         `PM_SEL_32S: sel_to_secs = `PM_TMO_32S;
         `PM_SEL_2M: sel_to_secs = `PM_TMO_2M;
         `PM_SEL_8M: sel_to_secs = `PM_TMO_8M;
         `PM_SEL_16M: sel_to_secs = `PM_TMO_16M;
         default: sel_to_secs = 10'h000;
      endcase
   endfunction
endpackage
`default_nettype wire

// file: rtl/idle_timer_if.sv
`default_nettype none
interface idle_timer_if;
   logic run;
   logic reload;
   logic [9:0] limit;
   logic expired;
   modport timer (input run, input reload, input limit, output expired);
   modport ctrl (output run, output reload, output limit, input expired);
endinterface
`default_nettype wire

// file: rtl/act_sync.sv
`default_nettype none
module act_sync #(
   parameter int W = 19
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // activity
   input wire logic [W-1:0] async,
   output logic [W-1:0] level
);
   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] level_ff;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end else begin
         s1_ff <= async;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // a bit changes only once second and third stages agree
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         level_ff <= '0;
      end else begin
         level_ff <= (s2_ff & s3_ff) | (level_ff & (s2_ff | s3_ff));
      end
   end

   assign level = level_ff;
endmodule
`default_nettype wire

// file: rtl/idle_timer.sv
`default_nettype none
module idle_timer (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // one-second tick
   input wire logic secTick,
   // control
   idle_timer_if.timer tm
);
   logic [9:0] count_ff;
   logic expired_ff;
   logic running_ff;
   logic restart;

   // a timer that has just started loads its full timeout first
   assign restart = !tm.run || tm.reload || !running_ff;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         running_ff <= 1'b0;
      end else begin
         running_ff <= tm.run;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         count_ff <= 10'h000;
      end else if (restart) begin
         count_ff <= tm.limit;
      end else if (secTick && count_ff != 10'h000) begin
         count_ff <= count_ff - 10'h001;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         expired_ff <= 1'b0;
      end else if (restart) begin
         expired_ff <= 1'b0;
      end else if (count_ff == 10'h000) begin
         expired_ff <= 1'b1;
      end
   end

   assign tm.expired = expired_ff;
endmodule
`default_nettype wire

// file: rtl/idle_power_state_timers.sv
// What this block does
// - global off: no saving, timers idle
// - user mode uses programmed timeout selections
// - minimum saving loads longest timeouts
// - maximum saving loads shortest timeouts
// - each state timer can be disabled
// - timeouts 8s, 32s, 2min, 8min, 16min
// - monitor six sources plus lines 3-15
// - doze reload: enabled and active source
// - standby reload: any enabled or active
// - suspend reload: any enabled or active
// - standby slows processor clock
// - disk off after interval or suspend
// - disk access restores disk power
// - disk never off when globally off
// - enabled interrupt activity wakes system
// - global setting resets to off
`include "pm_cfg.svh"
`default_nettype none
module idle_power_state_timers
   import pm_pkg::*;
#(
   parameter int unsigned SEC_CYCLES = `PM_SEC_CYCLES
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // activity inputs
   input wire logic [`PM_SRC_W-1:0] srcAct,
   input wire logic [`PM_IRQ_W-1:0] irqAct,
   // power controls
   output logic [1:0] pwrState,
   output logic cpuSlow,
   output logic diskPowerOn,
   output logic pmIrq
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   gmode_e gmode_ff;
   logic diskOnSusp_ff;
   logic [2:0] selDoze_ff;
   logic [2:0] selStby_ff;
   logic [2:0] selSusp_ff;
   logic [2:0] selDisk_ff;
   logic [`PM_ACT_W-1:0] actEn_ff;
   logic [`PM_EVT_W-1:0] intStat_ff;
   logic [`PM_EVT_W-1:0] intEn_ff;
   pm_state_e state_ff;
   pm_state_e nxt_state;
   logic cpuSlow_ff;
   logic diskPowerOn_ff;
   logic pmIrq_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic [23:0] secCnt_ff;
   logic secTick_ff;
   logic [`PM_ACT_W-1:0] actSync;

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   logic apbSetup;
   logic wrEn;
   logic addrHit;
   logic [31:0] rdMux;

   assign apbSetup = psel && !penable;
   assign wrEn = psel && penable && pready_ff && pwrite;

   always_comb begin
      addrHit = 1'b1;
      rdMux = 32'h0000_0000;
      case (paddr)
         `PM_CTRL_OFS: begin
            rdMux[`PM_CTRL_GMODE_LSB +: 2] = gmode_ff;
            rdMux[`PM_CTRL_DSUSP_BIT] = diskOnSusp_ff;
         end
         `PM_TMO_OFS: begin
            rdMux[`PM_TMO_DOZE_LSB +: 3] = selDoze_ff;
            rdMux[`PM_TMO_STBY_LSB +: 3] = selStby_ff;
            rdMux[`PM_TMO_SUSP_LSB +: 3] = selSusp_ff;
            rdMux[`PM_TMO_DISK_LSB +: 3] = selDisk_ff;
         end
         `PM_ACTEN_OFS: rdMux[`PM_ACT_W-1:0] = actEn_ff;
         `PM_STAT_OFS: begin
            rdMux[`PM_STAT_STATE_LSB +: 2] = state_ff;
            rdMux[`PM_STAT_SLOW_BIT] = cpuSlow_ff;
            rdMux[`PM_STAT_DISK_BIT] = diskPowerOn_ff;
            rdMux[`PM_STAT_ACT_LSB +: `PM_ACT_W] = actSync;
         end
         `PM_INTSTAT_OFS: rdMux[`PM_EVT_W-1:0] = intStat_ff;
         `PM_INTCLR_OFS: rdMux = 32'h0000_0000;
         `PM_INTEN_OFS: rdMux[`PM_EVT_W-1:0] = intEn_ff;
         default: addrHit = 1'b0;
      endcase
   end

   // zero wait states: ready in the first access cycle
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= apbSetup;
         pslverr_ff <= apbSetup && !addrHit;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata_ff <= 32'h0000_0000;
      end else if (apbSetup && !pwrite) begin
         prdata_ff <= rdMux;
      end
   end

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   // global off at reset
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         gmode_ff <= GM_OFF;
         diskOnSusp_ff <= 1'b0;
      end else if (wrEn && paddr == `PM_CTRL_OFS) begin
         gmode_ff <= gmode_e'(pwdata[`PM_CTRL_GMODE_LSB +: 2]);
         diskOnSusp_ff <= pwdata[`PM_CTRL_DSUSP_BIT];
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         selDoze_ff <= `PM_SEL_DIS;
         selStby_ff <= `PM_SEL_DIS;
         selSusp_ff <= `PM_SEL_DIS;
         selDisk_ff <= `PM_SEL_DIS;
      end else if (wrEn && paddr == `PM_TMO_OFS) begin
         selDoze_ff <= pwdata[`PM_TMO_DOZE_LSB +: 3];
         selStby_ff <= pwdata[`PM_TMO_STBY_LSB +: 3];
         selSusp_ff <= pwdata[`PM_TMO_SUSP_LSB +: 3];
         selDisk_ff <= pwdata[`PM_TMO_DISK_LSB +: 3];
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         actEn_ff <= '0;
      end else if (wrEn && paddr == `PM_ACTEN_OFS) begin
         actEn_ff <= pwdata[`PM_ACT_W-1:0];
      end
   end

   // ----------------------------------------
   // activity inputs
   // ----------------------------------------
   // sources then lines 3..15
   act_sync #(
      .W(`PM_ACT_W)
   ) u_sync (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .async({irqAct, srcAct}),
      .level(actSync)
   );

   logic pmOn;
   logic activeEn;
   logic looseAny;
   logic wake;
   logic diskAccess;

   assign pmOn = gmode_ff != GM_OFF;
   assign activeEn = |(actEn_ff & actSync);
   assign looseAny = |(actEn_ff | actSync);
   assign wake = pmOn && state_ff != PM_FULL && activeEn;
   assign diskAccess = actSync[`PM_ACT_DISK_BIT];

   // ----------------------------------------
   // one-second tick
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         secCnt_ff <= 24'h00_0000;
         secTick_ff <= 1'b0;
      end else if (secCnt_ff == 24'(SEC_CYCLES - 1)) begin
         secCnt_ff <= 24'h00_0000;
         secTick_ff <= 1'b1;
      end else begin
         secCnt_ff <= secCnt_ff + 24'h00_0001;
         secTick_ff <= 1'b0;
      end
   end

   // ----------------------------------------
   // idle timers: doze, standby, suspend, disk
   // ----------------------------------------
   logic [2:0] effSel [4];
   logic [3:0] reloadVec;
   logic [3:0] expVec;

   always_comb begin
      case (gmode_ff)
         GM_USER: begin
            effSel[0] = selDoze_ff;
            effSel[1] = selStby_ff;
            effSel[2] = selSusp_ff;
            effSel[3] = selDisk_ff;
         end
         GM_MIN: effSel = '{`PM_SEL_16M, `PM_SEL_16M, `PM_SEL_16M, `PM_SEL_16M};
         GM_MAX: effSel = '{`PM_SEL_8S, `PM_SEL_8S, `PM_SEL_8S, `PM_SEL_8S};
         default: effSel = '{`PM_SEL_DIS, `PM_SEL_DIS, `PM_SEL_DIS, `PM_SEL_DIS};
      endcase
   end

   assign reloadVec[0] = activeEn || wake;
   assign reloadVec[1] = looseAny || wake;
   assign reloadVec[2] = looseAny || wake;
   assign reloadVec[3] = diskAccess || wake;

   idle_timer_if tmr[4] ();

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_tmr
         assign tmr[gi].run = pmOn && effSel[gi] != `PM_SEL_DIS;
         assign tmr[gi].limit = sel_to_secs(effSel[gi]);
         assign tmr[gi].reload = reloadVec[gi];
         assign expVec[gi] = tmr[gi].expired;
         idle_timer u_tmr (
            .ref_clk(ref_clk),
            .reset_n(reset_n),
            .secTick(secTick_ff),
            .tm(tmr[gi].timer)
         );
      end
   endgenerate

   // ----------------------------------------
   // power state
   // ----------------------------------------
   always_comb begin
      nxt_state = state_ff;
      if (!pmOn) begin
         nxt_state = PM_FULL;
      end else if (wake) begin
         nxt_state = PM_FULL;
      end else begin
         case (state_ff)
            PM_FULL, PM_DOZE, PM_STANDBY: begin
               if (expVec[2]) begin
                  nxt_state = PM_SUSPEND;
               end else if (expVec[1] && state_ff != PM_STANDBY) begin
                  nxt_state = PM_STANDBY;
               end else if (expVec[0] && state_ff == PM_FULL) begin
                  nxt_state = PM_DOZE;
               end
            end
            PM_SUSPEND: nxt_state = PM_SUSPEND;
            default: nxt_state = PM_FULL;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= PM_FULL;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cpuSlow_ff <= 1'b0;
      end else begin
         cpuSlow_ff <= nxt_state == PM_STANDBY || nxt_state == PM_SUSPEND;
      end
   end

   // ----------------------------------------
   // disk power
   // ----------------------------------------
   logic diskDown;

   assign diskDown = expVec[3] || (diskOnSusp_ff && state_ff == PM_SUSPEND);

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         diskPowerOn_ff <= 1'b1;
      end else if (!pmOn) begin
         diskPowerOn_ff <= 1'b1;
      end else if (diskAccess || wake) begin
         diskPowerOn_ff <= 1'b1;
      end else if (diskDown) begin
         diskPowerOn_ff <= 1'b0;
      end
   end

   // ----------------------------------------
   // interrupts
   // ----------------------------------------
   logic [`PM_EVT_W-1:0] evt;
   logic [`PM_EVT_W-1:0] clrMask;

   always_comb begin
      evt = '0;
      evt[`PM_EVT_DOZE] = nxt_state == PM_DOZE && state_ff != PM_DOZE;
      evt[`PM_EVT_STBY] = nxt_state == PM_STANDBY && state_ff != PM_STANDBY;
      evt[`PM_EVT_SUSP] = nxt_state == PM_SUSPEND && state_ff != PM_SUSPEND;
      evt[`PM_EVT_WAKE] = wake;
      evt[`PM_EVT_DISKOFF] = diskPowerOn_ff && pmOn && !diskAccess && !wake && diskDown;
   end

   assign clrMask = (wrEn && paddr == `PM_INTCLR_OFS) ? pwdata[`PM_EVT_W-1:0] : '0;

   // set wins over clear
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         intStat_ff <= '0;
      end else begin
         intStat_ff <= (intStat_ff & ~clrMask) | evt;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         intEn_ff <= '0;
      end else if (wrEn && paddr == `PM_INTEN_OFS) begin
         intEn_ff <= pwdata[`PM_EVT_W-1:0];
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pmIrq_ff <= 1'b0;
      end else begin
         pmIrq_ff <= |(intStat_ff & intEn_ff);
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign pwrState = state_ff;
   assign cpuSlow = cpuSlow_ff;
   assign diskPowerOn = diskPowerOn_ff;
   assign pmIrq = pmIrq_ff;
endmodule
`default_nettype wire

// file: tb/idle_power_state_timers_props.sv
`default_nettype none
module idle_power_state_timers_props #(
   parameter int unsigned SEC_CYCLES = 10
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // activity and power
   input wire logic [5:0] srcAct,
   input wire logic [12:0] irqAct,
   input wire logic [1:0] pwrState,
   input wire logic cpuSlow,
   input wire logic diskPowerOn,
   input wire logic pmIrq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] mode_ff;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_ff <= 2'h0;
      end else if (psel && penable && pready && pwrite && paddr == 8'h00) begin
         mode_ff <= pwdata[1:0];
      end
   end
   AST_OFF_FULL: assert property (mode_ff == 2'h0 [*3] |-> pwrState == 2'h0)
      else $error("state not full while globally off");
   AST_OFF_DISK: assert property (mode_ff == 2'h0 [*3] |-> diskPowerOn)
      else $error("disk off while globally off");
   AST_SLOW_STATE: assert property (cpuSlow == pwrState[1])
      else $error("slow clock request does not match state");
   AST_DEEPEN: assert property ($changed(pwrState) && pwrState != 2'h0 |->
      pwrState > $past(pwrState))
      else $error("state moved to a shallower saving state");
   AST_WAKE_FULL: assert property ($changed(pwrState) && pwrState == 2'h0 |->
      !cpuSlow ##[0:1] diskPowerOn)
      else $error("return to full without full speed and disk power");
   AST_DISK_ACCESS: assert property (srcAct[3] [*6] |-> ##[0:1] diskPowerOn)
      else $error("disk access did not restore disk power");
   AST_PREADY_ACK: assert property (psel && !penable |=> pready && penable)
      else $error("no ready in first access cycle");
   AST_PREADY_PULSE: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   AST_BAD_ADDR: assert property (psel && !penable && paddr > 8'h18 |=> pslverr)
      else $error("no error for unmapped address");
   AST_GOOD_ADDR: assert property (psel && !penable && paddr <= 8'h18 && paddr[1:0] == 2'h0
      |=> !pslverr)
      else $error("error on mapped address");
endmodule

bind idle_power_state_timers idle_power_state_timers_props #(.SEC_CYCLES(SEC_CYCLES)) props (
   .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .srcAct(srcAct), .irqAct(irqAct), .pwrState(pwrState), .cpuSlow(cpuSlow),
   .diskPowerOn(diskPowerOn), .pmIrq(pmIrq));
`default_nettype wire

// file: tb/pm_activity_model.sv
`default_nettype none
module pm_activity_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // bench requests
   input wire logic [18:0] want,
   // disk power from the block
   input wire logic diskPowerOn,
   // activity levels
   output logic [5:0] srcAct,
   output logic [12:0] irqAct
);
   timeunit 1ns;
   timeprecision 1ns;
   // a disk request keeps asking until the disk is powered
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         srcAct <= 6'h00;
         irqAct <= 13'h0000;
      end else begin
         srcAct <= want[5:0] | {2'h0, srcAct[3] & ~diskPowerOn, 3'h0};
         irqAct <= want[18:6];
      end
   end
endmodule
`default_nettype wire

// file: tb/tb_idle_power_state_timers.sv
`include "pm_cfg.svh"
`default_nettype none
module tb_idle_power_state_timers;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int SC = 10;
   logic ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, cpuSlow, diskPowerOn, pmIrq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [5:0] srcAct;
   logic [12:0] irqAct;
   logic [1:0] pwrState;
   logic [18:0] act;
   logic err;
   int errTotal, numChecks, n, j;

   idle_power_state_timers #(.SEC_CYCLES(SC)) DUT (
      .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .srcAct(srcAct), .irqAct(irqAct), .pwrState(pwrState), .cpuSlow(cpuSlow),
      .diskPowerOn(diskPowerOn), .pmIrq(pmIrq));
   pm_activity_model partner (.ref_clk(ref_clk), .reset_n(reset_n), .want(act),
      .diskPowerOn(diskPowerOn), .srcAct(srcAct), .irqAct(irqAct));

   always #50 ref_clk = ~ref_clk;

   // ----------------------------------------
   // bench tasks
   // ----------------------------------------
   task automatic endOfTest;
      $display("checks %0d mismatches %0d", numChecks, errTotal);
      if (errTotal == 0 && numChecks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      numChecks++;
      if (got !== exp) begin
         errTotal++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic hang;
      chk(32'h0, 32'h1);
      endOfTest();
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      for (k = 0; k < 8; k++) begin
         @(posedge ref_clk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k == 8) hang();
   endtask

   task automatic waitState(input logic [1:0] s, input int lim);
      n = 0;
      while (pwrState !== s && n < lim) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= lim) hang();
   endtask

   function automatic int tmoSecs(input int code);
      case (code)
         1: return 8;
         2: return 32;
         3: return 120;
         4: return 480;
         default: return 960;
      endcase
   endfunction

   initial begin
      repeat (60000) @(posedge ref_clk);
      hang();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      ref_clk = 0;
      reset_n = 0;
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = 0;
      pwdata = 0;
      act = 0;
      errTotal = 0;
      numChecks = 0;
      void'($urandom(32'h44206a70));
      repeat (4) @(posedge ref_clk);
      reset_n <= 1'b1;
      chk({pwrState, cpuSlow, diskPowerOn, pmIrq}, 5'b00010);
      apb(0, `PM_CTRL_OFS, 0);
      chk(rd, 32'h0);
      apb(0, `PM_STAT_OFS, 0);
      chk(rd, 32'h8);
      apb(1, 8'h1c, $urandom);
      chk(err, 1'b1);
      apb(1, `PM_TMO_OFS, 32'h1111);
      repeat (30 * SC) @(posedge ref_clk);
      chk(pwrState, 2'h0);
      chk(diskPowerOn, 1'b1);
      for (int c = 1; c <= 5; c++) begin
         apb(1, `PM_CTRL_OFS, 32'h0);
         apb(1, `PM_TMO_OFS, c);
         apb(1, `PM_CTRL_OFS, 32'h1);
         waitState(2'h1, 1000 * SC);
         chk(n >= (tmoSecs(c) - 1) * SC && n <= (tmoSecs(c) + 2) * SC, 1'b1);
         chk(cpuSlow, 1'b0);
      end
      apb(1, `PM_CTRL_OFS, 32'h0);
      apb(1, `PM_TMO_OFS, 32'h0010);
      apb(1, `PM_CTRL_OFS, 32'h1);
      waitState(2'h2, 12 * SC);
      chk(cpuSlow, 1'b1);
      repeat (20 * SC) @(posedge ref_clk);
      chk(pwrState, 2'h2);
      apb(1, `PM_ACTEN_OFS, 32'h1 << $urandom_range(18));
      for (int c = 4; c <= 8; c += 4) begin
         apb(1, `PM_CTRL_OFS, 32'h0);
         apb(1, `PM_TMO_OFS, 32'h1 << c);
         apb(1, `PM_CTRL_OFS, 32'h1);
         repeat (15 * SC) @(posedge ref_clk);
         chk(pwrState, 2'h0);
      end
      apb(1, `PM_ACTEN_OFS, 32'h0);
      apb(1, `PM_CTRL_OFS, 32'h0);
      apb(1, `PM_TMO_OFS, 32'h0);
      apb(1, `PM_CTRL_OFS, 32'h7);
      waitState(2'h3, 12 * SC);
      chk(n >= 7 * SC, 1'b1);
      repeat (4) @(posedge ref_clk);
      chk(diskPowerOn, 1'b0);
      act[3] <= 1'b1;
      repeat (10) @(posedge ref_clk);
      chk({pwrState, diskPowerOn}, 3'b111);
      act[3] <= 1'b0;
      apb(1, `PM_INTEN_OFS, 32'h1f);
      repeat (2) @(posedge ref_clk);
      chk(pmIrq, 1'b1);
      apb(1, `PM_INTEN_OFS, 32'h0);
      repeat (2) @(posedge ref_clk);
      chk(pmIrq, 1'b0);
      apb(0, `PM_INTSTAT_OFS, 0);
      chk(rd[2], 1'b1);
      apb(1, `PM_INTCLR_OFS, 32'h1f);
      apb(0, `PM_INTSTAT_OFS, 0);
      chk(rd, 32'h0);
      apb(1, `PM_CTRL_OFS, 32'h0);
      repeat (3) @(posedge ref_clk);
      chk({pwrState, cpuSlow, diskPowerOn}, 4'b0001);
      apb(1, `PM_CTRL_OFS, 32'h2);
      repeat (950 * SC) @(posedge ref_clk);
      chk(pwrState, 2'h0);
      waitState(2'h3, 20 * SC);
      apb(1, `PM_CTRL_OFS, 32'h0);
      apb(1, `PM_TMO_OFS, 32'h1);
      apb(1, `PM_INTEN_OFS, 32'h8);
      apb(1, `PM_CTRL_OFS, 32'h1);
      for (int i = 0; i < 19; i++) begin
         apb(1, `PM_ACTEN_OFS, 32'h1 << i);
         waitState(2'h1, 12 * SC);
         chk(n >= 6 * SC, 1'b1);
         j = (i + 1 + $urandom_range(17)) % 19;
         act[j] <= 1'b1;
         repeat (8) @(posedge ref_clk);
         act[j] <= 1'b0;
         chk(pwrState, 2'h1);
         act[i] <= 1'b1;
         waitState(2'h0, 12);
         apb(0, `PM_STAT_OFS, 0);
         chk(rd[4 + i], 1'b1);
         chk(pmIrq, 1'b1);
         act[i] <= 1'b0;
         apb(1, `PM_INTCLR_OFS, 32'h8);
      end
      endOfTest();
   end
endmodule
`default_nettype wire
